// ---- dv/ccc_config_regs_assertions.sv ----
// Purpose: port assertions for the config register bank
// Assumes: one clock, sync active-low reset
// Notes: bound to the design from the bench
`timescale 1ns/1ps
module ccc_regs_chk (
    input wire clk, // clock
    input wire rst_n, // reset
    input wire cop_rd, // read
    input wire cop_wr, // write
    input wire [4:0] cop_reg, // number
    input wire [2:0] cop_sel, // select
    input wire [31:0] cop_wdata, // wdata
    input wire [31:0] cop_rdata, // rdata
    input wire cop_rvalid, // valid
    input wire [2:0] upper_kernel_seg_cache, // policy
    input wire [2:0] user_seg_cache_policy, // policy
    input wire [2:0] low_kernel_seg_cache // policy
);
    wire [8:0] pol = {upper_kernel_seg_cache, user_seg_cache_policy,
        low_kernel_seg_cache};
    wire rc = cop_rd && cop_reg == 5'h10;
    wire pwr = cop_wr && cop_reg == 5'h10 && cop_sel == 3'h0;
    wire [8:0] wpol = {cop_wdata[30:25], cop_wdata[2:0]};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (cop_rd |=> cop_rvalid)
        else $error("read not answered");
    a_prim_const: assert property (rc && cop_sel == 3'h0 |=>
        {cop_rdata[31], cop_rdata[24:22], cop_rdata[20:3]} == 22'h2020B0)
        else $error("primary constant bits wrong");
    a_prim_fields: assert property (rc && cop_sel == 3'h0 |=>
        cop_rdata[30:25] == $past(pol[8:3])
        && cop_rdata[2:0] == $past(pol[2:0]))
        else $error("primary policy bits wrong");
    a_idle_quiet: assert property (!cop_rd |=> !cop_rvalid
        && cop_rdata == 32'h00000000) else $error("output without read");
    a_caps_word: assert property (rc && cop_sel == 3'h1 |=>
        cop_rdata == 32'h80000006) else $error("capability word wrong");
    a_outer_word: assert property (rc && cop_sel == 3'h2 |=>
        cop_rdata == 32'h80000000) else $error("outer cache word wrong");
    a_ext_bits: assert property (rc && cop_sel == 3'h3 |=>
        !cop_rdata[31] && cop_rdata[5]) else $error("extension bits wrong");
    a_index_zero: assert property (cop_rd && cop_reg == 5'h0F &&
        cop_sel == 3'h1 |=> cop_rdata[9:0] == 10'h000) else $error("index");
    a_pol_load: assert property (pwr |=>
        pol == $past(wpol)) else $error("load");
    a_pol_hold: assert property (!pwr |=> $stable(pol))
        else $error("policy changed without write");
    c_pol_write: cover property (pwr);
    c_rw_same: cover property (cop_rd && pwr);
    c_back2back: cover property (cop_rd ##1 cop_rd);
endmodule

// ---- dv/ccc_config_regs_tb.sv ----
// Purpose: self-checking bench for the config register bank
// Assumes: 25 MHz clock, sync active-low reset
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module ccc_config_regs_tb;
    reg clk = 1'h0;
    reg rst_n = 1'h0;
    reg cop_rd = 1'h0;
    reg cop_wr = 1'h0;
    reg [4:0] cop_reg = 5'h00;
    reg [2:0] cop_sel = 3'h0;
    reg [31:0] cop_wdata = 32'h00000000;
    reg [31:0] rv;
    wire [31:0] cop_rdata;
    wire cop_rvalid;
    wire [2:0] fu, fs, fl;
    integer fails = 0;
    integer total_checks = 0;
    integer i;
    always #20 clk = ~clk;
    ccc_config_regs u_ccc_config_regs (.clk, .rst_n, .cop_rd, .cop_wr,
        .cop_reg, .cop_sel, .cop_wdata, .cop_rdata, .cop_rvalid,
        .upper_kernel_seg_cache(fu), .user_seg_cache_policy(fs),
        .low_kernel_seg_cache(fl));
    function [31:0] pexp(input [2:0] a, input [2:0] b, input [2:0] c);
        pexp = 32'h80210580 | {1'h0, a, b, 22'h000000, c};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // strobes stay up until the next call, so calls may run back to back
    task xfer(input r, input w, input [4:0] n, input [2:0] s,
        input [31:0] d);
        begin
            cop_rd = r;
            cop_wr = w;
            cop_reg = n;
            cop_sel = s;
            cop_wdata = d;
            @(posedge clk);
            #1 rv = cop_rdata;
            if (r) chk({31'h0, cop_rvalid}, 32'h1);
        end
    endtask
    task ro_words;
        begin
            xfer(1'h1, 1'h0, 5'h10, 3'h1, 32'h0);
            chk(rv, 32'h80000006);
            xfer(1'h1, 1'h0, 5'h10, 3'h2, 32'h0);
            chk(rv, 32'h80000000);
            xfer(1'h1, 1'h0, 5'h10, 3'h3, 32'h0);
            chk(rv & 32'h80000020, 32'h00000020);
            xfer(1'h1, 1'h0, 5'h0F, 3'h1, 32'h0);
            chk(rv & 32'h000003FF, 32'h0);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks=%0d fails=%0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #200000;
        fails = fails + 1;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'h1;
        xfer(1'h1, 1'h0, 5'h10, 3'h0, 32'h0);
        chk(rv, pexp(3'h2, 3'h2, 3'h2));
        ro_words;
        $display("test reset values done");
        // reserved bits written as zero, constant bits as one
        for (i = 0; i < 2; i = i + 1) begin
            xfer(1'h0, 1'h1, 5'h10, 3'h0,
                32'h8071FF80 | pexp(3'h2 + i, 3'h3 - i, 3'h2 + i));
            xfer(1'h1, 1'h0, 5'h10, 3'h0, 32'h0);
            chk(rv, pexp(3'h2 + i, 3'h3 - i, 3'h2 + i));
        end
        xfer(1'h1, 1'h1, 5'h10, 3'h0, pexp(3'h2, 3'h2, 3'h2));
        chk(rv, pexp(3'h3, 3'h2, 3'h3));
        for (i = 1; i < 4; i = i + 1)
            xfer(1'h0, 1'h1, 5'h10, i[2:0], 32'hFFFFFFFF);
        xfer(1'h0, 1'h1, 5'h0F, 3'h1, 32'hFFFFFFFF);
        chk({23'h0, fu, fs, fl}, 32'h00000092);
        ro_words;
        xfer(1'h1, 1'h0, 5'h03, 3'h0, 32'h0);
        chk(rv, 32'h0);
        xfer(1'h0, 1'h0, 5'h00, 3'h0, 32'h0);
        $display("test writes done");
        tally_and_finish;
    end
endmodule
bind ccc_config_regs ccc_regs_chk u_ccc_regs_chk (.clk, .rst_n, .cop_rd,
    .cop_wr, .cop_reg, .cop_sel, .cop_wdata, .cop_rdata, .cop_rvalid,
    .upper_kernel_seg_cache, .user_seg_cache_policy, .low_kernel_seg_cache);

// ---- shared/ccc_defines.vh ----
// Purpose: constants for the core capability and configuration registers
// Assumes: coprocessor register/select addressing, 32-bit data
// Notes: header only, definitions only
`ifndef CCC_DEFINES_VH
`define CCC_DEFINES_VH

// coprocessor register numbers and selects
`define CCC_REG_EXC_BASE 5'h0F
`define CCC_SEL_EXC_BASE 3'h1
`define CCC_REG_CONFIG 5'h10
`define CCC_SEL_PRIMARY 3'h0
`define CCC_SEL_CAPS 3'h1
`define CCC_SEL_OUTER 3'h2
`define CCC_SEL_EXT 3'h3

// primary register field positions
`define CCC_NEXT_BIT 31
`define CCC_K23_HI 30
`define CCC_K23_LO 28
`define CCC_KU_HI 27
`define CCC_KU_LO 25
`define CCC_CUSTOM_BIT 22
`define CCC_BYTE_LANE_BIT 21
`define CCC_MULDIV_BIT 20
`define CCC_DUAL_SRAM_BIT 16
`define CCC_ENDIAN_BIT 15
`define CCC_ISA_KIND_HI 14
`define CCC_ISA_KIND_LO 13
`define CCC_ISA_REV_HI 12
`define CCC_ISA_REV_LO 10
`define CCC_XLAT_HI 9
`define CCC_XLAT_LO 7
`define CCC_K0_HI 2
`define CCC_K0_LO 0

// capability register field positions
`define CCC_COMPACT_BIT 2
`define CCC_DEBUG_PORT_BIT 1
// extension register field positions
`define CCC_VEC_IRQ_BIT 5
`define CCC_EXT_CTRL_BIT 6

// cacheability encodings
`define CCC_CACHE_UNCACHED 3'h2
`define CCC_CACHE_CACHEABLE 3'h3

// reset values of writable fields
`define CCC_K23_RST 3'h2
`define CCC_KU_RST 3'h2
`define CCC_K0_RST 3'h2

// constant field values
`define CCC_ISA_KIND_VAL 2'h0
`define CCC_ISA_REV_VAL 3'h1
`define CCC_XLAT_VAL 3'h3
`define CCC_PROC_INDEX_VAL 10'h000

`endif

// ---- src/ccc_config_regs.v ----
// Purpose: capability/configuration register bank of the control coprocessor
// Assumes: coprocessor move port, at most one read and one write per cycle, core clock
// Notes: only the three cacheability fields and the read data/valid outputs hold state; the rest is wired
//
// Overview of operation
// - processor index in low ten bits of exception base reads zero
// - primary register loaded by reset, other fields are constants
// - three writable 3-bit cacheability fields at 30-28, 27-25, 2-0
// - cacheability code 2 means uncached, code 3 means cacheable
// - bit 31 of primary, first and second registers reads one
// - primary reserved bits 24-23, 19-17, 6-3 read zero, write zero
// - custom instruction flag bit 22 reads zero
// - bit 21 reports plain byte lanes on the internal bus
// - multiply/divide kind bit 20 reads zero, the fast unit
// - bit 16 reads one, separate instruction and data buses
// - byte order bit 15 reads zero, little-endian only
// - architecture kind field 14-13 reads 00
// - architecture revision field 12-10 reads 001
// - translation kind field 9-7 reads 3, fixed mapping
// - first configuration register is read-only
// - translation buffer size field 30-25 reads zero
// - all cache geometry fields of first register read zero
// - coprocessor, media, counter, watch and float bits read zero
// - compressed instruction set bit 2 reads one
// - debug port bit 1 reads one
// - second register read-only, bits 30-0 read zero
// - third register read-only, bit 31 reads zero
// - third register bit 5 reads one, vectored interrupts
`timescale 1ns/1ps
`include "ccc_defines.vh"

module ccc_config_regs #(
    parameter PLAIN_BYTE_LANE = 1'b1, // byte-enable mode strap value
    parameter EXT_IRQ_CTRL = 1'b1 // external interrupt controller support
) (
    input wire clk, // core clock, 25 MHz
    input wire rst_n, // synchronous reset, active low
    input wire cop_rd, // coprocessor move-from strobe
    input wire cop_wr, // coprocessor move-to strobe
    input wire [4:0] cop_reg, // coprocessor register number
    input wire [2:0] cop_sel, // register select
    input wire [31:0] cop_wdata, // write data
    output reg [31:0] cop_rdata, // read data, registered
    output reg cop_rvalid, // read data valid, one cycle
    output reg [2:0] upper_kernel_seg_cache, // upper kernel segment policy
    output reg [2:0] user_seg_cache_policy, // user segment policy
    output reg [2:0] low_kernel_seg_cache // low kernel segment policy
);

    // access decode: one word answers per register number and select
    wire sel_config;
    wire hit_primary;
    wire hit_exc_base;
    wire wr_primary;
    wire wr_upper_kernel;
    wire wr_user_seg;
    wire wr_low_kernel;

    // next values; the three policy fields and the read data/valid outputs hold state
    reg [2:0] k23_nxt;
    reg [2:0] ku_nxt;
    reg [2:0] k0_nxt;
    reg [31:0] config_word;
    reg [31:0] rdata_nxt;
    reg rvalid_nxt;

    // exception base word as seen from this bank
    wire [9:0] processor_index;
    wire [21:0] exc_base_rest;
    wire [31:0] exc_base_val;

    // primary register: fixed fields
    wire next_cfg_primary;
    wire custom_insn_flag;
    wire plain_byte_lane_flag;
    wire mul_div_kind;
    wire dual_sram_flag;
    wire endian_order_flag;
    wire [1:0] isa_kind;
    wire [2:0] isa_revision;
    wire [2:0] translation_kind;

    // primary register: reserved gaps
    wire [1:0] prim_rsvd_hi;
    wire [2:0] prim_rsvd_mid;
    wire [3:0] prim_rsvd_lo;
    wire [31:0] primary_val;

    // capability register: translation and cache geometry
    wire next_cfg_caps;
    wire [5:0] tlb_entry_count;
    wire [2:0] icache_sets_field;
    wire [2:0] icache_line_field;
    wire [2:0] icache_assoc_field;
    wire [2:0] dcache_sets_field;
    wire [2:0] dcache_line_field;
    wire [2:0] dcache_assoc_field;

    // capability register: optional units
    wire aux_coproc_present;
    wire media_ext_present;
    wire perf_counter_present;
    wire watch_regs_present;
    wire compact_isa_present;
    wire debug_port_present;
    wire float_unit_present;
    wire [31:0] caps_val;

    // second configuration register
    wire next_cfg_outer;
    wire [30:0] outer_cache_rsvd;
    wire [31:0] outer_val;

    // third configuration register
    wire next_cfg_none;
    wire [23:0] ext_rsvd_hi;
    wire ext_irq_ctrl_flag;
    wire vectored_irq_flag;
    wire small_page_flag;
    wire [1:0] ext_rsvd_lo;
    wire isa_ext_flag;
    wire trace_logic_flag;
    wire [31:0] ext_val;

    assign sel_config = (cop_reg == `CCC_REG_CONFIG);
    assign hit_primary = sel_config && (cop_sel == `CCC_SEL_PRIMARY);
    assign hit_exc_base = (cop_reg == `CCC_REG_EXC_BASE)
        && (cop_sel == `CCC_SEL_EXC_BASE);

    // read-only words ignore writes simply by having no write path
    assign wr_primary = cop_wr && hit_primary;
    // each policy field gets its own enable for later per-field masking
    assign wr_upper_kernel = wr_primary;
    assign wr_user_seg = wr_primary;
    assign wr_low_kernel = wr_primary;

    // a single core reads zero; a multi-core build would strap this
    assign processor_index = `CCC_PROC_INDEX_VAL;
    // vector base bits live with the exception logic, not here
    assign exc_base_rest = 22'h000000;
    assign exc_base_val = {exc_base_rest, processor_index};

    // another word follows this one
    assign next_cfg_primary = 1'b1;
    // no user-defined instructions
    assign custom_insn_flag = 1'b0;
    // strap, so a bus variant can change it without touching logic
    assign plain_byte_lane_flag = PLAIN_BYTE_LANE;
    // fast multiply/divide unit
    assign mul_div_kind = 1'b0;
    // separate instruction and data buses
    assign dual_sram_flag = 1'b1;
    // little-endian only, no byte swap anywhere
    assign endian_order_flag = 1'b0;
    // 32-bit base architecture
    assign isa_kind = `CCC_ISA_KIND_VAL;
    // second release of the architecture
    assign isa_revision = `CCC_ISA_REV_VAL;
    // fixed-mapping translation
    assign translation_kind = `CCC_XLAT_VAL;

    // reserved gaps read zero whatever software wrote into them
    assign prim_rsvd_hi = 2'h0;
    assign prim_rsvd_mid = 3'h0;
    assign prim_rsvd_lo = 4'h0;

    assign primary_val = {next_cfg_primary,
        upper_kernel_seg_cache,
        user_seg_cache_policy,
        prim_rsvd_hi,
        custom_insn_flag,
        plain_byte_lane_flag,
        mul_div_kind,
        prim_rsvd_mid,
        dual_sram_flag,
        endian_order_flag,
        isa_kind,
        isa_revision,
        translation_kind,
        prim_rsvd_lo,
        low_kernel_seg_cache};

    assign next_cfg_caps = 1'b1;
    // no translation buffer, so entry count minus one is zero
    assign tlb_entry_count = 6'h00;
    // no instruction cache
    assign icache_sets_field = 3'h0;
    assign icache_line_field = 3'h0;
    assign icache_assoc_field = 3'h0;
    // no data cache
    assign dcache_sets_field = 3'h0;
    assign dcache_line_field = 3'h0;
    assign dcache_assoc_field = 3'h0;

    // no second coprocessor attached
    assign aux_coproc_present = 1'b0;
    // no media extension
    assign media_ext_present = 1'b0;
    // no performance counters
    assign perf_counter_present = 1'b0;
    // no watch registers
    assign watch_regs_present = 1'b0;
    // compressed 16-bit instruction set is built in
    assign compact_isa_present = 1'b1;
    // on-chip debug port is always there
    assign debug_port_present = 1'b1;
    // no floating-point unit
    assign float_unit_present = 1'b0;

    // wholly wired, so a write here has nothing to change
    assign caps_val = {next_cfg_caps,
        tlb_entry_count,
        icache_sets_field,
        icache_line_field,
        icache_assoc_field,
        dcache_sets_field,
        dcache_line_field,
        dcache_assoc_field,
        aux_coproc_present,
        media_ext_present,
        perf_counter_present,
        watch_regs_present,
        compact_isa_present,
        debug_port_present,
        float_unit_present};

    assign next_cfg_outer = 1'b1;
    // no level-2 or level-3 cache to describe
    assign outer_cache_rsvd = 31'h00000000;
    assign outer_val = {next_cfg_outer, outer_cache_rsvd};

    // end of the chain: software stops walking here
    assign next_cfg_none = 1'b0;
    // unused positions
    assign ext_rsvd_hi = 24'h000000;
    // strap for an external interrupt controller
    assign ext_irq_ctrl_flag = EXT_IRQ_CTRL;
    // vectored interrupts are always built in
    assign vectored_irq_flag = 1'b1;
    // no small-page support
    assign small_page_flag = 1'b0;
    // unused positions
    assign ext_rsvd_lo = 2'h0;
    // no security instruction extension
    assign isa_ext_flag = 1'b0;
    // no trace logic
    assign trace_logic_flag = 1'b0;

    assign ext_val = {next_cfg_none,
        ext_rsvd_hi,
        ext_irq_ctrl_flag,
        vectored_irq_flag,
        small_page_flag,
        ext_rsvd_lo,
        isa_ext_flag,
        trace_logic_flag};

    // any 3-bit code is stored; 2 and 3 are the defined policies
    always @* begin
        if (wr_upper_kernel) begin
            k23_nxt = cop_wdata[`CCC_K23_HI:`CCC_K23_LO];
        end else begin
            k23_nxt = upper_kernel_seg_cache;
        end
    end

    always @* begin
        if (wr_user_seg) begin
            ku_nxt = cop_wdata[`CCC_KU_HI:`CCC_KU_LO];
        end else begin
            ku_nxt = user_seg_cache_policy;
        end
    end

    always @* begin
        if (wr_low_kernel) begin
            k0_nxt = cop_wdata[`CCC_K0_HI:`CCC_K0_LO];
        end else begin
            k0_nxt = low_kernel_seg_cache;
        end
    end

    // select within the configuration number first
    always @* begin
        case (cop_sel)
            `CCC_SEL_PRIMARY: begin
                config_word = primary_val;
            end
            `CCC_SEL_CAPS: begin
                config_word = caps_val;
            end
            `CCC_SEL_OUTER: begin
                config_word = outer_val;
            end
            `CCC_SEL_EXT: begin
                config_word = ext_val;
            end
            default: begin
                config_word = 32'h00000000;
            end
        endcase
    end

    // unmapped numbers answer zero so the pipeline never waits
    always @* begin
        rdata_nxt = 32'h00000000;
        if (!cop_rd) begin
            rdata_nxt = 32'h00000000;
        end else if (sel_config) begin
            rdata_nxt = config_word;
        end else if (hit_exc_base) begin
            rdata_nxt = exc_base_val;
        end
    end

    // every read is answered, mapped or not
    always @* begin
        rvalid_nxt = cop_rd;
    end

    // reset brings every policy field up uncached
    always @(posedge clk) begin
        if (!rst_n) begin
            upper_kernel_seg_cache <= `CCC_K23_RST;
        end else begin
            upper_kernel_seg_cache <= k23_nxt;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            user_seg_cache_policy <= `CCC_KU_RST;
        end else begin
            user_seg_cache_policy <= ku_nxt;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            low_kernel_seg_cache <= `CCC_K0_RST;
        end else begin
            low_kernel_seg_cache <= k0_nxt;
        end
    end

    // a read in the write's cycle still sees the old contents
    always @(posedge clk) begin
        if (!rst_n) begin
            cop_rdata <= 32'h00000000;
        end else begin
            cop_rdata <= rdata_nxt;
        end
    end

    // valid is a one-cycle pulse per accepted read
    always @(posedge clk) begin
        if (!rst_n) begin
            cop_rvalid <= 1'b0;
        end else begin
            cop_rvalid <= rvalid_nxt;
        end
    end

endmodule
